/* hdl/ser_reporter.sv */
// Purpose: service request, status byte and event code reporting unit
// Assumes: poll, query and command strobes come from logic on mclk_i
// Notes:   event store is current slot, pending slot and a stack
`default_nettype none
// Operation
// - enabled event raises service request
// - serial poll drops request unless the pending byte requests, returns status
// - event query returns code paired with poll
// - request bit only with request mode, fixed one in power on and user bytes
// - busy bit from acquisition modes at request
// - fatal, power on, user byte layouts
// - error status byte layouts
// - execution status byte layouts
// - one current, one pending byte, ranked
// - higher rank replaces pending status byte
// - fatal goes direct, locks all but poll
// - fatal error makes no event code
// - forty event codes held in total
// - outranking code displaces pending into stack
// - others pushed; oldest lost when full
// - query promotes pending code to current
// - codes 108 to 162 are command errors
// - second poll without query drops code
// - request mode off: no request but power on and fatal, stack direct
// - per class enables under master enable
// - query before poll returns pending marker
module ser_reporter #(
  parameter logic [7:0] SRQ_PENDING_CODE = 8'hFE,  // arbitrary marker value
  parameter int         LIFO_DEPTH       = ser_pkg::SER_EVT_TOTAL - 2
) (
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [31:0]         reg_rdata_o,
  input  wire logic                event_valid_i,
  input  wire ser_pkg::ser_class_e event_class_i,
  input  wire logic [7:0]          event_code_i,
  output logic                     event_ready_o,
  input  wire logic                fatal_i,
  input  wire logic                serial_poll_i,
  input  wire logic                event_query_i,
  input  wire logic                bus_cmd_i,
  output logic                     bus_cmd_accept_o,
  output logic                     srq_o,
  output logic      [7:0]          status_byte_o,
  output logic                     status_valid_o,
  output logic      [7:0]          event_code_o,
  output logic                     event_valid_o
);
  logic [12:0]         ctrl_reg;
  logic                lock_reg, srq_reg, cur_sb_v_reg, pend_sb_v_reg, pend_srq_reg;
  logic [7:0]          cur_sb_reg, pend_sb_reg;
  logic [1:0]          pend_sb_rank_reg;
  logic [7:0]          ev_cur_reg, ev_pend_reg;
  logic [1:0]          ev_pend_rank_reg;
  logic                ev_cur_v_reg, ev_pend_v_reg, polled_reg;
  ser_pkg::ser_class_e cls;
  logic [7:0]          new_sb, idle_sb;
  logic [1:0]          new_rank;
  logic                request_service_master_enable, busy, want_srq, accept, query_ok, drop, consume;
  logic                outranks, push, pop, lifo_empty;
  logic [9:0]          push_data, lifo_top;
  logic [5:0]          lifo_cnt, total_cnt;

  // a set class enable only counts under the master enable
  function automatic logic class_srq_en(input ser_pkg::ser_class_e c, input logic [12:0] ctl);
    logic m;
    m = ctl[ser_pkg::SER_CTL_MASTER];
    case (c)
      ser_pkg::SER_CL_POWER_ON:  class_srq_en = 1'b1;
      ser_pkg::SER_CL_CMD_ERR:   class_srq_en = m && ctl[ser_pkg::SER_CTL_CER];
      ser_pkg::SER_CL_EXEC_ERR:  class_srq_en = m && ctl[ser_pkg::SER_CTL_EXR];
      ser_pkg::SER_CL_INT_ERR:   class_srq_en = m && ctl[ser_pkg::SER_CTL_INR];
      ser_pkg::SER_CL_EXEC_WARN: class_srq_en = m && ctl[ser_pkg::SER_CTL_EXW];
      ser_pkg::SER_CL_OP_CMPL:   class_srq_en = m && ctl[ser_pkg::SER_CTL_OPC];
      ser_pkg::SER_CL_USER_REQ:  class_srq_en = m && ctl[ser_pkg::SER_CTL_USER];
      ser_pkg::SER_CL_PROBE_ID:  class_srq_en = m && ctl[ser_pkg::SER_CTL_PID];
      ser_pkg::SER_CL_INT_WARN:  class_srq_en = m;
      default:                   class_srq_en = 1'b0;
    endcase
  endfunction

  // command error codes keep their class whatever the source claims
  always_comb begin
    cls = event_class_i;
    if (event_code_i >= ser_pkg::SER_EVC_CMD_LO && event_code_i <= ser_pkg::SER_EVC_CMD_HI) begin
      cls = ser_pkg::SER_CL_CMD_ERR;
    end
  end

  assign request_service_master_enable  = ctrl_reg[ser_pkg::SER_CTL_MASTER];
  assign busy = |ctrl_reg[ser_pkg::SER_CTL_ACQ_HI:ser_pkg::SER_CTL_ACQ_LO];

  ser_status_encode u_enc (
    .class_i (fatal_i ? ser_pkg::SER_CL_FATAL : cls),
    .rqs_i   (request_service_master_enable),
    .busy_i  (busy),
    .sbyte_o (new_sb),
    .rank_o  (new_rank)
  );

  // byte sent when nothing is queued: rank 3, busy still reported
  always_comb begin
    idle_sb = ser_pkg::SER_SB_NONE;
    idle_sb[ser_pkg::SER_BIT_X] = busy;
  end

  // after a fatal error everything but serial poll is refused
  assign bus_cmd_accept_o = bus_cmd_i && !lock_reg;
  assign event_ready_o    = !lock_reg && !fatal_i && !serial_poll_i && !event_query_i;
  assign accept           = event_valid_i && event_ready_o;
  assign want_srq         = class_srq_en(cls, ctrl_reg);
  assign query_ok         = event_query_i && !lock_reg;
  // a second poll with no query between throws the unread code away
  assign drop             = serial_poll_i && !lock_reg && polled_reg;
  assign consume          = drop || (query_ok && !(srq_reg && !polled_reg));
  assign outranks         = !ev_pend_v_reg || new_rank < ev_pend_rank_reg;

  // stack traffic: displaced or low ranked codes go in, consumes pull out
  always_comb begin
    push      = 1'b0;
    push_data = {new_rank, event_code_i};
    pop       = consume && !lifo_empty;
    if (accept) begin
      if (!request_service_master_enable) begin
        push = 1'b1;
      end else if (ev_cur_v_reg) begin
        push = !outranks || ev_pend_v_reg;
        if (outranks) begin
          push_data = {ev_pend_rank_reg, ev_pend_reg};
        end
      end
    end
  end

  ser_lifo #(
    .WIDTH (10),
    .DEPTH (LIFO_DEPTH)
  ) u_lifo (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .push_i      (push),
    .push_data_i (push_data),
    .pop_i       (pop),
    .top_o       (lifo_top),
    .empty_o     (lifo_empty),
    .count_o     (lifo_cnt)
  );

  // total held, current and pending slots included
  assign total_cnt = lifo_cnt + 6'(ev_cur_v_reg) + 6'(ev_pend_v_reg);

  // control register written by software
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_reg <= ser_pkg::SER_CTL_RESET;
    end else if (reg_wr_i && reg_addr_i == ser_pkg::SER_OFS_CTRL) begin
      ctrl_reg <= reg_wdata_i[12:0];
    end
  end

  // register read data one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ser_pkg::SER_OFS_CTRL:  reg_rdata_o <= {19'h0, ctrl_reg};
        ser_pkg::SER_OFS_STAT:  reg_rdata_o <= {18'h0, total_cnt, 4'h0, pend_sb_v_reg,
                                                 cur_sb_v_reg, lock_reg, srq_reg};
        ser_pkg::SER_OFS_SBYTE: reg_rdata_o <= {24'h0, cur_sb_reg};
        ser_pkg::SER_OFS_EVCUR: reg_rdata_o <= {24'h0, ev_cur_reg};
        default:                reg_rdata_o <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // status byte path: current in the interface plus one pending byte
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lock_reg         <= 1'b0;
      srq_reg          <= 1'b0;
      cur_sb_reg       <= ser_pkg::SER_SB_NONE;
      cur_sb_v_reg     <= 1'b0;
      pend_sb_reg      <= ser_pkg::SER_SB_NONE;
      pend_sb_v_reg    <= 1'b0;
      pend_sb_rank_reg <= ser_pkg::SER_RANK_LOW;
      pend_srq_reg     <= 1'b0;
      status_byte_o    <= ser_pkg::SER_SB_NONE;
      status_valid_o   <= 1'b0;
    end else begin
      status_valid_o <= serial_poll_i;
      if (fatal_i && !lock_reg) begin
        cur_sb_reg    <= new_sb;
        cur_sb_v_reg  <= 1'b1;
        srq_reg       <= 1'b1;    // raised whatever the request mode
        lock_reg      <= 1'b1;
        pend_sb_v_reg <= 1'b0;
      end else if (serial_poll_i) begin
        status_byte_o <= cur_sb_v_reg ? cur_sb_reg : idle_sb;
        if (!lock_reg) begin
          cur_sb_reg    <= pend_sb_reg;
          cur_sb_v_reg  <= pend_sb_v_reg;
          srq_reg       <= pend_sb_v_reg && pend_srq_reg;
          pend_sb_v_reg <= 1'b0;
        end else begin
          srq_reg <= 1'b0;  // fatal byte stays for later polls
        end
      end else if (accept) begin
        if (!cur_sb_v_reg) begin
          cur_sb_reg   <= new_sb;
          cur_sb_v_reg <= 1'b1;
          srq_reg      <= srq_reg || want_srq;
        end else if (!pend_sb_v_reg || new_rank < pend_sb_rank_reg) begin
          pend_sb_reg      <= new_sb;
          pend_sb_v_reg    <= 1'b1;
          pend_sb_rank_reg <= new_rank;
          pend_srq_reg     <= want_srq;
        end
      end
    end
  end

  // event code path; a fatal error never enters it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ev_cur_reg       <= ser_pkg::SER_EVC_EMPTY;
      ev_cur_v_reg     <= 1'b0;
      ev_pend_reg      <= ser_pkg::SER_EVC_EMPTY;
      ev_pend_v_reg    <= 1'b0;
      ev_pend_rank_reg <= ser_pkg::SER_RANK_LOW;
      polled_reg       <= 1'b0;
      event_code_o     <= ser_pkg::SER_EVC_EMPTY;
      event_valid_o    <= 1'b0;
    end else begin
      event_valid_o <= query_ok;
      if (serial_poll_i && !lock_reg) begin
        polled_reg <= 1'b1;
      end else if (query_ok) begin
        polled_reg <= 1'b0;
      end
      if (query_ok) begin
        if (srq_reg && !polled_reg) begin
          event_code_o <= SRQ_PENDING_CODE;
        end else if (ev_cur_v_reg) begin
          event_code_o <= ev_cur_reg;
        end else if (ev_pend_v_reg) begin
          event_code_o <= ev_pend_reg;
        end else begin
          event_code_o <= lifo_empty ? ser_pkg::SER_EVC_EMPTY : lifo_top[7:0];
        end
      end
      if (consume) begin
        // the front entry leaves and the chain moves up one place
        if (ev_cur_v_reg) begin
          ev_cur_reg    <= ev_pend_v_reg ? ev_pend_reg : lifo_top[7:0];
          ev_cur_v_reg  <= ev_pend_v_reg || !lifo_empty;
          ev_pend_v_reg <= ev_pend_v_reg && !lifo_empty;
        end else if (ev_pend_v_reg) begin
          ev_pend_v_reg <= !lifo_empty;
        end
        ev_pend_reg      <= lifo_top[7:0];
        ev_pend_rank_reg <= lifo_top[9:8];
      end else if (accept && request_service_master_enable) begin
        if (!ev_cur_v_reg) begin
          ev_cur_reg   <= event_code_i;
          ev_cur_v_reg <= 1'b1;
        end else if (outranks) begin
          ev_pend_reg      <= event_code_i;
          ev_pend_rank_reg <= new_rank;
          ev_pend_v_reg    <= 1'b1;
        end
      end
    end
  end

  assign srq_o = srq_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_poll;
    serial_poll_i && !fatal_i && !lock_reg;
  endsequence
  sequence s_query_paired;
    event_query_i && !lock_reg && polled_reg && ev_cur_v_reg;
  endsequence

  property p_poll_releases;
    s_poll and !pend_sb_v_reg |=> status_valid_o && !srq_o;
  endproperty
  a_poll_releases: assert property (p_poll_releases) else $error("poll left request up");

  property p_lock_refuses;
    lock_reg |-> !bus_cmd_accept_o && !event_ready_o;
  endproperty
  a_lock_refuses: assert property (p_lock_refuses) else $error("locked unit took a command");

  property p_fatal_direct;
    fatal_i && !lock_reg |=> srq_o && cur_sb_reg[7] && cur_sb_reg[3:0] == 4'h3
                             && total_cnt == $past(total_cnt);
  endproperty
  a_fatal_direct: assert property (p_fatal_direct) else $error("fatal byte not loaded alone");

  property p_rqs_off_quiet;
    accept && !request_service_master_enable && !cur_sb_v_reg && !srq_reg && event_class_i != ser_pkg::SER_CL_POWER_ON
      // user and probe bytes carry a fixed one in the request bit position
      && event_class_i != ser_pkg::SER_CL_USER_REQ && event_class_i != ser_pkg::SER_CL_PROBE_ID
      && !(event_code_i >= ser_pkg::SER_EVC_CMD_LO && event_code_i <= ser_pkg::SER_EVC_CMD_HI)
      |=> !srq_o && !cur_sb_reg[ser_pkg::SER_BIT_R];
  endproperty
  a_rqs_off_quiet: assert property (p_rqs_off_quiet) else $error("request raised with mode off");

  property p_srq_marker;
    event_query_i && !lock_reg && srq_reg && !polled_reg
      |=> event_valid_o && event_code_o == SRQ_PENDING_CODE;
  endproperty
  a_srq_marker: assert property (p_srq_marker) else $error("pending marker not returned");

  property p_capacity;
    total_cnt <= 6'(ser_pkg::SER_EVT_TOTAL);
  endproperty
  a_capacity: assert property (p_capacity) else $error("more than forty codes held");

  property p_promote;
    s_query_paired and ev_pend_v_reg |=> event_code_o == $past(ev_cur_reg)
                                         && ev_cur_reg == $past(ev_pend_reg);
  endproperty
  a_promote: assert property (p_promote) else $error("pending code not promoted");

  property p_double_poll;
    s_poll and polled_reg and ev_cur_v_reg and !event_valid_i
      |=> total_cnt == $past(total_cnt) - 6'h01;
  endproperty
  a_double_poll: assert property (p_double_poll) else $error("stale code not dropped");

  property p_pend_replace;
    accept && cur_sb_v_reg && pend_sb_v_reg && new_rank < pend_sb_rank_reg
      |=> pend_sb_reg == $past(new_sb) ##1 1'b1;
  endproperty
  a_pend_replace: assert property (p_pend_replace) else $error("pending byte not replaced");
endmodule
`default_nettype wire

/* hdl/ser_pkg.sv */
// Purpose: shared constants and types of the status and event reporter
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   status byte layouts hold X cleared, R set only in power on and user; the logic ors R in
`default_nettype none
package ser_pkg;
  // event classes; fatal is only raised through its own input
  typedef enum logic [3:0] {
    SER_CL_NONE, SER_CL_POWER_ON, SER_CL_CMD_ERR, SER_CL_USER_REQ,
    SER_CL_EXEC_ERR, SER_CL_INT_ERR, SER_CL_EXEC_WARN, SER_CL_INT_WARN,
    SER_CL_OP_CMPL, SER_CL_PROBE_ID, SER_CL_FATAL
  } ser_class_e;

  localparam int          SER_EVT_W      = 8;
  localparam int          SER_RANK_W     = 2;
  localparam int          SER_EVT_TOTAL  = 40;  // current slot counts too
  // status byte bit positions
  localparam int          SER_BIT_R      = 6;
  localparam int          SER_BIT_X      = 4;
  // status byte bases, X clear, R set only in power on and user
  localparam logic [7:0]  SER_SB_FATAL   = 8'hA3;
  localparam logic [7:0]  SER_SB_POWER   = 8'h41;
  localparam logic [7:0]  SER_SB_USER    = 8'h43;
  localparam logic [7:0]  SER_SB_CMD     = 8'h21;
  localparam logic [7:0]  SER_SB_EXEC    = 8'h22;
  localparam logic [7:0]  SER_SB_INT     = 8'h23;
  localparam logic [7:0]  SER_SB_EXWARN  = 8'h25;
  localparam logic [7:0]  SER_SB_INWARN  = 8'h26;
  localparam logic [7:0]  SER_SB_OPC     = 8'h02;
  localparam logic [7:0]  SER_SB_NONE    = 8'h00;
  // ranks, lower is more urgent
  localparam logic [1:0]  SER_RANK_TOP   = 2'h1;
  localparam logic [1:0]  SER_RANK_MID   = 2'h2;
  localparam logic [1:0]  SER_RANK_LOW   = 2'h3;
  // command error code range and named codes
  localparam logic [7:0]  SER_EVC_CMD_LO = 8'h6C;  // 108 checksum failure
  localparam logic [7:0]  SER_EVC_BADCNT = 8'h6D;  // 109 bad byte count
  localparam logic [7:0]  SER_EVC_CMD_HI = 8'hA2;  // 162
  localparam logic [7:0]  SER_EVC_EMPTY  = 8'h00;
  // register offsets
  localparam logic [7:0]  SER_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  SER_OFS_STAT   = 8'h04;
  localparam logic [7:0]  SER_OFS_SBYTE  = 8'h08;
  localparam logic [7:0]  SER_OFS_EVCUR  = 8'h0C;
  // control fields
  localparam int          SER_CTL_MASTER = 0;
  localparam int          SER_CTL_CER    = 1;
  localparam int          SER_CTL_EXR    = 2;
  localparam int          SER_CTL_INR    = 3;
  localparam int          SER_CTL_EXW    = 4;
  localparam int          SER_CTL_OPC    = 5;
  localparam int          SER_CTL_USER   = 6;
  localparam int          SER_CTL_PID    = 7;
  localparam int          SER_CTL_ACQ_LO = 8;   // five acquisition modes
  localparam int          SER_CTL_ACQ_HI = 12;
  localparam logic [12:0] SER_CTL_RESET  = 13'h00FF;
endpackage
`default_nettype wire

/* hdl/ser_status_encode.sv */
// Purpose: builds a status byte and its rank from an event class
// Assumes: purely combinational
// Notes:   probe identify reports as a user request byte
`default_nettype none
module ser_status_encode (
  input  wire ser_pkg::ser_class_e class_i,
  input  wire logic                rqs_i,
  input  wire logic                busy_i,
  output logic [7:0]               sbyte_o,
  output logic [1:0]               rank_o
);
  logic [7:0] base;

  // base byte and rank per class
  always_comb begin
    rank_o = ser_pkg::SER_RANK_MID;
    case (class_i)
      ser_pkg::SER_CL_FATAL: begin
        base   = ser_pkg::SER_SB_FATAL;
        rank_o = ser_pkg::SER_RANK_TOP;
      end
      ser_pkg::SER_CL_POWER_ON: begin
        base   = ser_pkg::SER_SB_POWER;
        rank_o = ser_pkg::SER_RANK_TOP;
      end
      ser_pkg::SER_CL_USER_REQ:  base = ser_pkg::SER_SB_USER;
      ser_pkg::SER_CL_PROBE_ID:  base = ser_pkg::SER_SB_USER;
      ser_pkg::SER_CL_CMD_ERR:   base = ser_pkg::SER_SB_CMD;
      ser_pkg::SER_CL_EXEC_ERR:  base = ser_pkg::SER_SB_EXEC;
      ser_pkg::SER_CL_INT_ERR:   base = ser_pkg::SER_SB_INT;
      ser_pkg::SER_CL_INT_WARN:  base = ser_pkg::SER_SB_INWARN;
      ser_pkg::SER_CL_EXEC_WARN: base = ser_pkg::SER_SB_EXWARN;
      ser_pkg::SER_CL_OP_CMPL:   base = ser_pkg::SER_SB_OPC;
      default: begin
        base   = ser_pkg::SER_SB_NONE;
        rank_o = ser_pkg::SER_RANK_LOW;
      end
    endcase
  end

  // R from the base or with request mode on, X only when busy; no-status never carries R
  always_comb begin
    sbyte_o = base;
    sbyte_o[ser_pkg::SER_BIT_R] = base[ser_pkg::SER_BIT_R]
                                | (rqs_i && rank_o != ser_pkg::SER_RANK_LOW);
    sbyte_o[ser_pkg::SER_BIT_X] = busy_i;
  end
endmodule
`default_nettype wire

/* hdl/ser_lifo.sv */
// Purpose: last-in first-out store of event codes with their ranks
// Assumes: push and pop may come together; pop then returns the old top
// Notes:   a push into a full store silently loses the oldest entry
`default_nettype none
module ser_lifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 38
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] top_o,
  output logic                  empty_o,
  output logic      [5:0]       count_o
);
  logic [WIDTH-1:0] stack_reg [DEPTH];
  logic [5:0]       count_reg;

  assign top_o   = stack_reg[0];
  assign empty_o = (count_reg == 6'h00);
  assign count_o = count_reg;

  // shifting stack: the bottom entry falls off on overflow
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (push_i && !pop_i) begin
        stack_reg[i] <= (i == 0) ? push_data_i : stack_reg[(i > 0) ? i - 1 : 0];
      end else if (push_i && pop_i) begin
        if (i == 0) begin
          stack_reg[i] <= push_data_i;
        end
      end else if (pop_i) begin
        stack_reg[i] <= (i == DEPTH - 1) ? '0 : stack_reg[(i < DEPTH - 1) ? i + 1 : i];
      end
    end
  end

  // occupancy saturates at the depth
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      count_reg <= 6'h00;
    end else if (push_i && !pop_i && count_reg != 6'(DEPTH)) begin
      count_reg <= count_reg + 6'h01;
    end else if (pop_i && !push_i && !empty_o) begin
      count_reg <= count_reg - 6'h01;
    end
  end
endmodule
`default_nettype wire

/* verif/ser_ctl_model.sv */
// Purpose: bus controller model issuing serial polls and event queries
// Assumes: strobes change right after a rising edge, one cycle long
// Notes:   answers are taken one cycle after the request edge
`default_nettype none
module ser_ctl_model (
  input  wire logic       mclk_i,
  output logic            poll_o,
  output logic            query_o,
  input  wire logic [7:0] sbyte_i,
  input  wire logic       svalid_i,
  input  wire logic [7:0] code_i,
  input  wire logic       cvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle until the bench asks for a transfer
  initial begin
    poll_o = 1'b0;
    query_o = 1'b0;
  end
  // serial poll: the usual answer to a service request
  task automatic poll(output logic [7:0] b, output logic v);
    @(posedge mclk_i) poll_o <= 1'b1;
    @(posedge mclk_i) poll_o <= 1'b0;
    #1 b = sbyte_i;
    v = svalid_i;
  endtask
  // event query, normally sent after a poll to pair the code
  task automatic query(output logic [7:0] c, output logic v);
    @(posedge mclk_i) query_o <= 1'b1;
    @(posedge mclk_i) query_o <= 1'b0;
    #1 c = code_i;
    v = cvalid_i;
  endtask
endmodule
`default_nettype wire

/* verif/ser_reporter_tb.sv */
// Purpose: self-checking bench of the status and event reporter
// Assumes: 100 MHz clock, reset held ten cycles
// Notes:   expected bytes carry the request bit unless request mode is off
`default_nettype none
module ser_reporter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, srst_i, reg_wr_i, reg_rd_i, ev_v, fatal_i, bus_cmd_i;
  logic [7:0]  reg_addr_i, ev_code, b, c, ev_code_o, sb_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic poll, qry, sb_v, ec_v, ready, accept, srq_o, v;
  ser_pkg::ser_class_e ev_cls;
  int err_total = 0;
  int total_checks = 0;
  ser_pkg::ser_class_e k_t [10] = '{ser_pkg::SER_CL_POWER_ON, ser_pkg::SER_CL_USER_REQ,
    ser_pkg::SER_CL_PROBE_ID, ser_pkg::SER_CL_CMD_ERR, ser_pkg::SER_CL_EXEC_ERR,
    ser_pkg::SER_CL_EXEC_ERR, ser_pkg::SER_CL_INT_ERR, ser_pkg::SER_CL_EXEC_WARN,
    ser_pkg::SER_CL_INT_WARN, ser_pkg::SER_CL_OP_CMPL};
  // codes 108 and 109 must come out as command errors whatever class is given
  logic [7:0] c_t [10] = '{8'h01, 8'h02, 8'h03, 8'h6C, 8'h6D, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  logic [7:0] e_t [10] = '{8'h41, 8'h43, 8'h43, 8'h61, 8'h61, 8'h62, 8'h63, 8'h65, 8'h66, 8'h42};

  ser_reporter DUT (.mclk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .event_valid_i(ev_v), .event_class_i(ev_cls), .event_code_i(ev_code),
    .event_ready_o(ready), .fatal_i, .serial_poll_i(poll), .event_query_i(qry),
    .bus_cmd_i, .bus_cmd_accept_o(accept), .srq_o, .status_byte_o(sb_o),
    .status_valid_o(sb_v), .event_code_o(ev_code_o), .event_valid_o(ec_v));
  ser_ctl_model ctl (.mclk_i, .poll_o(poll), .query_o(qry), .sbyte_i(sb_o),
    .svalid_i(sb_v), .code_i(ev_code_o), .cvalid_i(ec_v));

  // free running clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(logic [31:0] g, logic [31:0] e, string m);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] w);
    @(posedge mclk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, w};
    @(posedge mclk_i) reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    @(posedge mclk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge mclk_i) reg_rd_i <= 1'b0;
    #1 r = reg_rdata_o;
  endtask
  // hold the event until an edge sees ready high
  task automatic ev(ser_pkg::ser_class_e k, logic [7:0] cd);
    @(posedge mclk_i) {ev_v, ev_cls, ev_code} <= {1'b1, k, cd};
    do @(posedge mclk_i); while (ready !== 1'b1);
    ev_v <= 1'b0;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // a hang is cut short well past the expected run
  initial begin
    #200us;
    err_total++;
    stop_test();
  end

  initial begin
    {srst_i, reg_wr_i, reg_rd_i, ev_v, fatal_i, bus_cmd_i} = 6'h20;
    {reg_addr_i, ev_code, reg_wdata_i} = '0;
    ev_cls = ser_pkg::SER_CL_NONE;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(ser_pkg::SER_OFS_CTRL, d);
    chk(d, 32'h00FF, "ctrl reset");
    rd(8'h10, d);
    chk(d, 32'h0, "unmapped read");
    // query before poll while the request is up
    ev(ser_pkg::SER_CL_CMD_ERR, 8'h97);
    chk(srq_o, 1'b1, "srq raised");
    rd(ser_pkg::SER_OFS_STAT, d);
    chk(d, 32'h0000_0105, "stat one held");
    rd(ser_pkg::SER_OFS_SBYTE, d);
    chk(d, 32'h0000_0061, "current byte reg");
    rd(ser_pkg::SER_OFS_EVCUR, d);
    chk(d, 32'h0000_0097, "current code reg");
    ctl.query(c, v);
    chk({v, c}, {1'b1, 8'hFE}, "pending marker");
    ctl.poll(b, v);
    chk({v, b, srq_o}, {1'b1, 8'h61, 1'b0}, "poll byte");
    ctl.query(c, v);
    chk({v, c}, {1'b1, 8'h97}, "paired code");
    // every status byte layout but fatal, one class at a time
    for (int i = 0; i < 10; i++) begin
      ev(k_t[i], c_t[i]);
      ctl.poll(b, v);
      chk(b, e_t[i], "layout");
      ctl.query(c, v);
      chk(c, c_t[i], "layout code");
    end
    // ranking: power on replaces operation complete in the pending slot
    ev(ser_pkg::SER_CL_CMD_ERR, 8'h98);
    ev(ser_pkg::SER_CL_OP_CMPL, 8'h09);
    ev(ser_pkg::SER_CL_POWER_ON, 8'h0A);
    ctl.poll(b, v);
    chk({b, srq_o}, {8'h61, 1'b1}, "pending moves up");
    ctl.query(c, v);
    chk(c, 8'h98, "current code");
    ctl.poll(b, v);
    chk({b, srq_o}, {8'h41, 1'b0}, "higher rank kept");
    ctl.query(c, v);
    chk(c, 8'h0A, "promoted code");
    ctl.query(c, v);
    chk(c, 8'h09, "displaced code");
    // two polls with no query between drop the first code
    ev(ser_pkg::SER_CL_CMD_ERR, 8'h99);
    ev(ser_pkg::SER_CL_EXEC_ERR, 8'h0B);
    ctl.poll(b, v);
    ctl.poll(b, v);
    chk(b, 8'h62, "second byte");
    ctl.query(c, v);
    chk(c, 8'h0B, "code stays paired");
    // class enable off under the master enable
    wr(ser_pkg::SER_OFS_CTRL, 32'hFD);
    ev(ser_pkg::SER_CL_CMD_ERR, 8'h9A);
    chk(srq_o, 1'b0, "class masked");
    ctl.poll(b, v);
    ctl.query(c, v);
    // request mode off, averaging on: no srq, no R bit, busy bit set
    wr(ser_pkg::SER_OFS_CTRL, 32'h1FE);
    ev(ser_pkg::SER_CL_EXEC_ERR, 8'h0C);
    chk(srq_o, 1'b0, "no srq");
    ctl.poll(b, v);
    chk(b, 8'h32, "busy byte");
    ctl.query(c, v);
    chk(c, 8'h0C, "stack code");
    ctl.poll(b, v);
    chk(b, 8'h10, "no status busy");
    // overfill the store; total held stops at forty
    wr(ser_pkg::SER_OFS_CTRL, 32'hFF);
    for (int i = 0; i < 45; i++) ev(ser_pkg::SER_CL_CMD_ERR, 8'h9B);
    rd(ser_pkg::SER_OFS_STAT, d);
    chk(d[13:8], 6'h28, "forty held");
    @(posedge mclk_i) bus_cmd_i <= 1'b1;
    #1 chk(accept, 1'b1, "cmd accepted");
    // fatal locks everything but serial poll
    @(posedge mclk_i) {bus_cmd_i, fatal_i} <= 2'b01;
    @(posedge mclk_i) {bus_cmd_i, fatal_i} <= 2'b10;
    #1 chk({accept, srq_o}, 2'b01, "locked");
    ctl.poll(b, v);
    chk(b, 8'hE3, "fatal byte");
    ctl.query(c, v);
    chk(v, 1'b0, "no fatal code");
    stop_test();
  end
endmodule
`default_nettype wire
